// ==== hw/qlsl_ctrl.sv ====
/*
  Quad low-side serial latch control: serial shift register with daisy-chain
  output, strobe-loaded output stage, enable gating and protection faults.
  Assumes all pin inputs are asynchronous to clk and the serial clock is far
  slower than clk (period 80 ns or more), so edges are found by sampling.
*/
`default_nettype none
module qlsl_ctrl
  import qlsl_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          power_on_reset,
  input  wire logic                          undervoltage_lockout,
  input  wire logic                          serial_clk,
  input  wire logic                          serial_in,
  input  wire logic                          strobe,
  input  wire logic                          output_enable_n,
  input  wire logic [qlsl_pkg::CHANNELS-1:0] overcurrent_protect,
  input  wire logic                          thermal_shutdown,
  output logic                               serial_out,
  output logic [qlsl_pkg::CHANNELS-1:0]      channel_on,
  output logic                               fault_n
);
  import qlsl_pkg::*;

  typedef struct packed {
    logic [1:0]          sclk_sync;
    logic                sclk_last;
    logic [1:0]          din_sync;
    logic [1:0]          stb_sync;
    logic                stb_last;
    logic [1:0]          en_sync;
    logic [1:0]          ot_sync;
    logic [CHANNELS-1:0] oc_sync0;
    logic [CHANNELS-1:0] oc_sync1;
    logic [CHANNELS-1:0] shift;
    logic [CHANNELS-1:0] latched;
    logic [CHANNELS-1:0] drive;
    logic                sout;
    logic                fault_n;
  } qlsl_state_s;

  qlsl_state_s s_reg;
  qlsl_state_s s_next;

  logic                int_reset;
  logic [CHANNELS-1:0] oc_trip;

  // Power-up reset and undervoltage both act as reset, so state is defined
  // without the host pulsing the reset pin.
  assign int_reset = reset | power_on_reset | undervoltage_lockout;

  // One timer per channel; shared reset clears every pending retry.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_oc
      qlsl_oc_timer #(
        .DEGLITCH (CNT_W'(OC_DEGLITCH_CYC)),
        .RETRY    (CNT_W'(RETRY_CYC))
      ) u_oc (
        .clk      (clk),
        .reset    (int_reset),
        .limit_in (s_reg.oc_sync1[g]),
        .tripped  (oc_trip[g])
      );
    end
  endgenerate

  // Next state: sync pins, find edges, shift and latch, then gate drivers.
  always_comb
  begin
    s_next = s_reg;
    s_next.sclk_sync = {s_reg.sclk_sync[0], serial_clk};
    s_next.sclk_last = s_reg.sclk_sync[1];
    s_next.din_sync  = {s_reg.din_sync[0], serial_in};
    s_next.stb_sync  = {s_reg.stb_sync[0], strobe};
    s_next.stb_last  = s_reg.stb_sync[1];
    // An undriven pin arrives as low from the pad pulldown.
    s_next.en_sync   = {s_reg.en_sync[0], output_enable_n};
    s_next.ot_sync   = {s_reg.ot_sync[0], thermal_shutdown};
    s_next.oc_sync0  = overcurrent_protect;
    s_next.oc_sync1  = s_reg.oc_sync0;
    // Serial path ignores the enable entirely.
    if (s_reg.sclk_sync[1] && !s_reg.sclk_last)
    begin
      s_next.shift = {s_reg.shift[CHANNELS-2:0], s_reg.din_sync[1]};
      // The output mirrors the new last stage, so a chained device sees each bit after four clocks.
      s_next.sout  = s_reg.shift[CHANNELS-2];
    end
    if (s_reg.stb_sync[1] && !s_reg.stb_last)
      s_next.latched = s_reg.shift;
    // Thermal shutdown kills every channel; overcurrent only its own one.
    if (s_reg.en_sync[1] || s_reg.ot_sync[1])
      s_next.drive = CH_ZERO;
    else
      s_next.drive = s_reg.latched & ~oc_trip;
    s_next.fault_n = !(s_reg.ot_sync[1] || (|oc_trip));
  end

  // The whole serial path clears, so all channels start off.
  always_ff @(posedge clk or posedge int_reset)
  begin
    if (int_reset)
    begin
      s_reg         <= '0;
      s_reg.fault_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign serial_out = s_reg.sout;
  assign channel_on = s_reg.drive;
  assign fault_n    = s_reg.fault_n;

  property p_enable_off;
    @(posedge clk) disable iff (int_reset)
      s_reg.en_sync[1] |=> (channel_on == CH_ZERO);
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("Channel on while enable high.");

  property p_thermal_off;
    @(posedge clk) disable iff (int_reset)
      s_reg.ot_sync[1] |=> (channel_on == CH_ZERO) && !fault_n;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("Thermal shutdown not honoured.");

  property p_gate;
    @(posedge clk) disable iff (int_reset)
      1'b1 |=> channel_on == ($past(s_reg.en_sync[1]) || $past(s_reg.ot_sync[1]) ? CH_ZERO
                              : ($past(s_reg.latched) & ~$past(oc_trip)));
  endproperty
  a_gate: assert property (p_gate) else $error("Channel gating wrong.");

  property p_latch;
    @(posedge clk) disable iff (int_reset)
      (s_reg.stb_sync[1] && !s_reg.stb_last) |=> s_reg.latched == $past(s_reg.shift);
  endproperty
  a_latch: assert property (p_latch) else $error("Strobe did not load output stage.");

  property p_latch_hold;
    @(posedge clk) disable iff (int_reset)
      !(s_reg.stb_sync[1] && !s_reg.stb_last) |=> $stable(s_reg.latched);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Output stage changed without strobe.");

  property p_shift;
    @(posedge clk) disable iff (int_reset)
      (s_reg.sclk_sync[1] && !s_reg.sclk_last) |=>
        s_reg.shift[0] == $past(s_reg.din_sync[1]) && serial_out == $past(s_reg.shift[CHANNELS-2]);
  endproperty
  a_shift: assert property (p_shift) else $error("Shift or serial out wrong.");

  property p_sout_hold;
    @(posedge clk) disable iff (int_reset)
      !(s_reg.sclk_sync[1] && !s_reg.sclk_last) |=> $stable(serial_out) && $stable(s_reg.shift);
  endproperty
  a_sout_hold: assert property (p_sout_hold) else $error("Serial state moved without clock edge.");

  property p_oc_fault;
    @(posedge clk) disable iff (int_reset)
      (|oc_trip) |=> !fault_n && ((channel_on & $past(oc_trip)) == CH_ZERO);
  endproperty
  a_oc_fault: assert property (p_oc_fault) else $error("Overcurrent not reported.");

  property p_reset_clear;
    @(posedge clk) int_reset |-> channel_on == CH_ZERO && fault_n && !serial_out;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset left state set.");
endmodule
`default_nettype wire

// ==== hw/qlsl_pkg.sv ====
/*
  Package for the quad low-side serial latch control block: channel count,
  protection timing figures and the derived cycle counts at the 100 MHz clock.
  Assumes a single 100 MHz system clock domain.
*/
`default_nettype none
package qlsl_pkg;
  localparam int unsigned CHANNELS        = 4;
  localparam int unsigned CLK_MHZ         = 100;
  // Overcurrent deglitch time in nanoseconds (3.5 us).
  localparam int unsigned OC_DEGLITCH_NS  = 3500;
  // Retry interval in microseconds (1.2 ms).
  localparam int unsigned RETRY_US        = 1200;
  // Least time, so the cycle count rounds up.
  localparam int unsigned OC_DEGLITCH_CYC = (OC_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RETRY_CYC       = RETRY_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 18;
  localparam logic [CHANNELS-1:0] CH_ZERO = 4'h0;
  localparam logic [CNT_W-1:0]    CNT_ZERO = 18'h00000;
  localparam logic [CNT_W-1:0]    CNT_ONE  = 18'h00001;
endpackage
`default_nettype wire

// ==== hw/qlsl_oc_timer.sv ====
/*
  One overcurrent channel guard: deglitches the current-limit level, then holds
  the channel off for the retry interval. Assumes limit_in is already
  synchronised to clk.
*/
`default_nettype none
module qlsl_oc_timer
  import qlsl_pkg::*;
#(
  parameter logic [qlsl_pkg::CNT_W-1:0] DEGLITCH = 18'h0015e,
  parameter logic [qlsl_pkg::CNT_W-1:0] RETRY    = 18'h1d4c0
)
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic limit_in,
  output logic      tripped
);
  typedef enum logic [2:0] {
    QLSL_IDLE  = 3'b001,
    QLSL_GLTCH = 3'b010,
    QLSL_HOLD  = 3'b100
  } qlsl_oc_e;

  typedef struct packed {
    qlsl_oc_e         st;
    logic [CNT_W-1:0] cnt;
  } qlsl_oc_s;

  qlsl_oc_s s_reg;
  qlsl_oc_s s_next;

  // Deglitch counts limit cycles; a gap in the limit restarts the count.
  always_comb
  begin
    s_next = s_reg;
    unique case (s_reg.st)
      QLSL_IDLE:
      begin
        if (limit_in)
        begin
          s_next.st  = QLSL_GLTCH;
          s_next.cnt = CNT_ONE;
        end
      end
      QLSL_GLTCH:
      begin
        if (!limit_in)
          s_next.st = QLSL_IDLE;
        else if (s_reg.cnt >= DEGLITCH)
        begin
          s_next.st  = QLSL_HOLD;
          s_next.cnt = CNT_ZERO;
        end
        else
          s_next.cnt = s_reg.cnt + CNT_ONE;
      end
      QLSL_HOLD:
      begin
        if (s_reg.cnt >= RETRY - CNT_ONE)
        begin
          s_next.st  = QLSL_IDLE;
          s_next.cnt = CNT_ZERO;
        end
        else
          s_next.cnt = s_reg.cnt + CNT_ONE;
      end
      default:
        s_next = '{st: QLSL_IDLE, cnt: CNT_ZERO};
    endcase
  end

  // Reset clears a pending fault at once.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s_reg <= '{st: QLSL_IDLE, cnt: CNT_ZERO};
    else
      s_reg <= s_next;
  end

  assign tripped = (s_reg.st == QLSL_HOLD);

  property p_hold_ends;
    @(posedge clk) disable iff (reset)
      $rose(tripped) |-> tripped [*8];
  endproperty
  a_hold_ends: assert property (p_hold_ends) else $error("Retry hold ended too early.");
endmodule
`default_nettype wire

// ==== tb/qlsl_host_model.sv ====
/*
  Host model for the serial port: shifts words in on an 80 ns serial clock
  and strobes them. Assumes the 100 MHz bench clock for pacing.
*/
`default_nettype none
module qlsl_host_model
(
  input  wire logic clk,
  input  wire logic serial_out,
  output var logic  serial_clk,
  output var logic  serial_in,
  output var logic  strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] seen;

  // The clock is parked low between frames.
  initial
  begin
    serial_clk = 1'b0;
    serial_in  = 1'b0;
    strobe     = 1'b0;
    seen       = 4'h0;
  end

  // Sends the top bit first and samples the chained output before each rise.
  task automatic send_word(input logic [3:0] w);
    for (int i = 3; i >= 0; i--)
    begin
      // Data changes with the falling clock, giving an 80 ns serial period.
      serial_in = w[i];
      repeat (4) @(negedge clk);
      seen[i] = serial_out;
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
    end
    serial_in = ~w[0]; // Stale data is shown inverted, never as a valid bit.
  endtask

  // The long gap lets the last bit settle before the strobe rises.
  task automatic pulse_strobe();
    repeat (45) @(negedge clk);
    strobe = 1'b1;
    repeat (25) @(negedge clk);
    strobe = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_quad_low_side_serial_latch_ctrl.sv ====
/*
  Self-checking bench for the latch control block with a host model.
  Assumes a 100 MHz clock; the 1.2 ms retry is only partly observed.
*/
`default_nettype none
module tb_quad_low_side_serial_latch_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import qlsl_pkg::*;
  logic       clk;
  logic       reset;
  logic       por;
  logic       uv;
  logic       en_n;
  logic       en_float;
  logic       hot;
  logic [3:0] oc;
  logic [3:0] prev;
  logic [3:0] w;
  int         n_mismatch;
  int         check_count;
  wire        sclk;
  wire        sdin;
  wire        stb;
  wire        sdout;
  wire        fault_n;
  wire  [3:0] channel_on;
  tri0        en_pin;

  // The enable pin floats to its pulled-down level when released.
  assign en_pin = en_float ? 1'bz : en_n;

  qlsl_ctrl uut (.clk(clk), .reset(reset), .power_on_reset(por), .undervoltage_lockout(uv),
    .serial_clk(sclk), .serial_in(sdin), .strobe(stb), .output_enable_n(en_pin),
    .overcurrent_protect(oc), .thermal_shutdown(hot), .serial_out(sdout),
    .channel_on(channel_on), .fault_n(fault_n));

  qlsl_host_model host (.clk(clk), .serial_out(sdout), .serial_clk(sclk), .serial_in(sdin), .strobe(stb));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  task automatic check(input logic [4:0] seen, input logic [4:0] expd);
    check_count++;
    if (seen !== expd)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  function automatic logic [3:0] gated(input logic [3:0] word, input logic dis);
    return dis ? 4'h0 : word;
  endfunction

  // Shifts a word, checks what left the chain output, then strobes it.
  task automatic load(input logic [3:0] word);
    host.send_word(word);
    check(host.seen, prev);
    prev = word;
    host.pulse_strobe();
    check(sdout, word[3]);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  initial
  begin
    #500000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence; inputs change on the falling clock edge.
  initial
  begin
    clk = 0; reset = 1; por = 0; uv = 0; en_n = 0; en_float = 0; hot = 0; oc = 4'h0;
    n_mismatch = 0; check_count = 0; prev = 4'h0;
    void'($urandom(38771));
    wait_n(20);
    check(channel_on, 4'h0);
    check(sdout, 1'b0);
    check(fault_n, 1'b1);
    reset = 0;
    wait_n(5500);
    for (int i = 0; i < 10; i++)
    begin
      w = (i == 0) ? 4'h8 : (i == 1) ? 4'h1 : 4'($urandom);
      load(w);
      en_n = (i < 2) ? 1'b0 : 1'($urandom);
      wait_n(6);
      check(channel_on, gated(w, en_n));
    end
    en_n = 1;
    load(4'ha);
    check(channel_on, 4'h0);
    en_n = 0;
    wait_n(6);
    check(channel_on, 4'ha);
    host.send_word(4'h5);
    check(host.seen, prev);
    prev = 4'h5;
    en_float = 1;
    wait_n(60);
    check(channel_on, 4'ha);
    $display("test serial done");
    load(4'hf);
    hot = 1;
    wait_n(6);
    check({fault_n, channel_on}, 5'h00);
    hot = 0;
    wait_n(6);
    check({fault_n, channel_on}, 5'h1f);
    $display("test thermal done");
    oc = 4'h2;
    wait_n(340);
    check(fault_n, 1'b1);
    oc = 4'h0;
    wait_n(5);
    oc = 4'h2;
    wait_n(370);
    check({fault_n, channel_on}, 5'h0d);
    oc = 4'h0;
    wait_n(1000);
    check({fault_n, channel_on}, 5'h0d);
    reset = 1;
    wait_n(1);
    check({fault_n, channel_on}, 5'h10);
    reset = 0;
    prev = 4'h0;
    $display("test overcurrent done");
    for (int s = 0; s < 2; s++)
    begin
      load(4'h6);
      if (s == 0) uv = 1; else por = 1;
      wait_n(2);
      check({sdout, channel_on}, 5'h00);
      uv = 0; por = 0;
      wait_n(3);
      check({sdout, channel_on}, 5'h00);
      prev = 4'h0;
    end
    $display("test internal resets done");
    print_verdict();
  end
endmodule
`default_nettype wire
